//--- shared/dual_port_block_ram_map.vh
/*
  constants for the dual-port block memory: storage geometry, word layout,
  write-mode and output-select encodings.
  assumes it is included by bare name from the design files under logic/.
*/
`ifndef DUAL_PORT_BLOCK_RAM_MAP_VH
`define DUAL_PORT_BLOCK_RAM_MAP_VH

// storage geometry
`define BRAM_TOTAL_BITS 18432
`define BRAM_DATA_BITS 16384
`define BRAM_WORDS 512
`define BRAM_WORD_ADDR_W 9
`define BRAM_ADDR_BITS 14
`define BRAM_SLOT_BITS 5

// layout of one stored word: data [31:0], parity [35:32], parity bit i for byte i
`define BRAM_WORD_W 36
`define BRAM_FULL_DATA_W 32
`define BRAM_FULL_PAR_W 4
`define BRAM_PAR_LSB 32
`define BRAM_BYTE_W 8

// write modes
`define WM_WRITE_FIRST 2'h0
`define WM_READ_FIRST 2'h1
`define WM_NO_CHANGE 2'h2

// output select of a port
`define OSEL_MEM 2'h0
`define OSEL_HOLD 2'h1
`define OSEL_DEFAULT 2'h2

`endif

//--- logic/block_store.v
/*
  storage array of the block memory: 512 words of 36 bits, two ports on one
  clock, bit-masked writes, registered read data (old contents on a write).
  assumes the caller narrows/widens words and owns all output behaviour.
*/
`timescale 1ns/1ps
`include "dual_port_block_ram_map.vh"

module block_store #(
  parameter DEPTH = `BRAM_WORDS,
  parameter AW = `BRAM_WORD_ADDR_W,
  parameter W = `BRAM_WORD_W,
  parameter [W-1:0] INIT_WORD = 36'h000000000
) (
  // clock
  input wire clk,
  // port a
  input wire en_a,
  input wire we_a,
  input wire [AW-1:0] addr_a,
  input wire [W-1:0] wdata_a,
  input wire [W-1:0] wmask_a,
  output reg [W-1:0] rdata_a,
  // port b
  input wire en_b,
  input wire we_b,
  input wire [AW-1:0] addr_b,
  input wire [W-1:0] wdata_b,
  input wire [W-1:0] wmask_b,
  output reg [W-1:0] rdata_b
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [W-1:0] a_new;
  reg [W-1:0] b_base;
  reg [W-1:0] b_new;
  wire same_word = we_a && (addr_a == addr_b);
  integer i;

  // whole array preloaded with one fill word; per-location init is not offered
  initial begin
    for (i = 0; i < DEPTH; i = i + 1) begin
      mem[i] = INIT_WORD;
    end
  end

  // merged words, so two narrow ports hitting one word keep both slices
  always @* begin
    a_new = (mem[addr_a] & ~wmask_a) | (wdata_a & wmask_a);
    b_base = same_word ? a_new : mem[addr_b];
    b_new = (b_base & ~wmask_b) | (wdata_b & wmask_b);
  end

  // reads return contents before this edge's writes
  always @(posedge clk) begin
    if (en_a) begin
      rdata_a <= mem[addr_a];
    end
    if (en_b) begin
      rdata_b <= mem[addr_b];
    end
    if (we_a && !(we_b && same_word)) begin
      mem[addr_a] <= a_new;
    end
    if (we_b) begin
      mem[addr_b] <= b_new;
    end
  end

endmodule

//--- logic/dual_port_block_ram.v
/*
  dual-port block memory with per-port aspect ratio, bus matching, parity
  lanes, write modes and output set/reset.
  assumes both ports run on the single clk and user logic drives both ports.
*/
`timescale 1ns/1ps
`include "dual_port_block_ram_map.vh"

module dual_port_block_ram #(
  parameter DUAL_PORT = 1,
  parameter DATA_W_A = 32,
  parameter DATA_W_B = 32,
  parameter [1:0] WRITE_MODE_A = `WM_WRITE_FIRST,
  parameter [1:0] WRITE_MODE_B = `WM_WRITE_FIRST,
  parameter [35:0] OUT_DEFAULT_A = 36'h000000000,
  parameter [35:0] OUT_DEFAULT_B = 36'h000000000,
  parameter [35:0] INIT_WORD = 36'h000000000,
  parameter [0:0] INVERT_EN_A = 1'h0,
  parameter [0:0] INVERT_WE_A = 1'h0,
  parameter [0:0] INVERT_SSR_A = 1'h0,
  parameter [0:0] INVERT_EN_B = 1'h0,
  parameter [0:0] INVERT_WE_B = 1'h0,
  parameter [0:0] INVERT_SSR_B = 1'h0,
  parameter ADDR_W_A = `BRAM_ADDR_BITS - $clog2(DATA_W_A),
  parameter ADDR_W_B = `BRAM_ADDR_BITS - $clog2(DATA_W_B),
  parameter PAR_W_A = (DATA_W_A >= 8) ? DATA_W_A / 8 : 1,
  parameter PAR_W_B = (DATA_W_B >= 8) ? DATA_W_B / 8 : 1
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // port a controls
  input wire enable_a,
  input wire write_enable_a,
  input wire output_set_reset_a,
  input wire [ADDR_W_A-1:0] addr_a,
  // port a data
  input wire [DATA_W_A-1:0] write_data_bus_a,
  input wire [PAR_W_A-1:0] write_parity_bits_a,
  output wire [DATA_W_A-1:0] read_data_a,
  output wire [PAR_W_A-1:0] read_parity_bits_a,
  // port b controls
  input wire enable_b,
  input wire write_enable_b,
  input wire output_set_reset_b,
  input wire [ADDR_W_B-1:0] addr_b,
  // port b data
  input wire [DATA_W_B-1:0] write_data_bus_b,
  input wire [PAR_W_B-1:0] write_parity_bits_b,
  output wire [DATA_W_B-1:0] read_data_b,
  output wire [PAR_W_B-1:0] read_parity_bits_b,
  // shared multiplier operand lines
  output wire [15:0] mult_operand_a_upper,
  output wire [15:0] mult_operand_b_upper
);

  // narrow value placed in its slot of a 36-bit word, lowest slot lowest
  function [35:0] place;
    input [31:0] d;
    input [3:0] p;
    input [4:0] slot;
    input [5:0] dw;
    reg [32:0] dmask;
    reg [3:0] pmask;
    reg [10:0] sh;
    reg [2:0] psh;
    begin
      dmask = (33'h000000001 << dw) - 33'h000000001;
      pmask = (4'h1 << (dw >> 3)) - 4'h1;
      sh = {6'h00, slot} * {5'h00, dw};
      psh = sh[5:3];
      place = 36'h000000000;
      place[31:0] = (d & dmask[31:0]) << sh;
      place[35:32] = (p & pmask) << psh;
    end
  endfunction

  // slot of a stored word returned as {parity, data}, upper bits zero
  function [35:0] extract;
    input [35:0] w;
    input [4:0] slot;
    input [5:0] dw;
    reg [32:0] dmask;
    reg [3:0] pmask;
    reg [10:0] sh;
    reg [2:0] psh;
    begin
      dmask = (33'h000000001 << dw) - 33'h000000001;
      pmask = (4'h1 << (dw >> 3)) - 4'h1;
      sh = {6'h00, slot} * {5'h00, dw};
      psh = sh[5:3];
      extract = 36'h000000000;
      extract[31:0] = (w[31:0] >> sh) & dmask[31:0];
      extract[35:32] = (w[35:32] >> psh) & pmask;
    end
  endfunction

  // port inputs widened to full lanes
  wire [32+DATA_W_A-1:0] a_dcat = {32'h00000000, write_data_bus_a};
  wire [32+DATA_W_B-1:0] b_dcat = {32'h00000000, write_data_bus_b};
  wire [4+PAR_W_A-1:0] a_pcat = {4'h0, write_parity_bits_a};
  wire [4+PAR_W_B-1:0] b_pcat = {4'h0, write_parity_bits_b};
  wire [14+ADDR_W_A-1:0] a_acat = {14'h0000, addr_a};
  wire [14+ADDR_W_B-1:0] b_acat = {14'h0000, addr_b};

  wire [63:0] d32_all = {b_dcat[31:0], a_dcat[31:0]};
  wire [7:0] p4_all = {b_pcat[3:0], a_pcat[3:0]};
  wire [27:0] addr_all = {b_acat[13:0], a_acat[13:0]};
  // control polarity, single-port build keeps port b idle
  wire [1:0] en_all = {(enable_b ^ INVERT_EN_B) & (DUAL_PORT != 0),
                       enable_a ^ INVERT_EN_A};
  wire [1:0] we_all = {write_enable_b ^ INVERT_WE_B, write_enable_a ^ INVERT_WE_A};
  wire [1:0] ssr_all = {output_set_reset_b ^ INVERT_SSR_B,
                        output_set_reset_a ^ INVERT_SSR_A};

  wire [1:0] mem_en;
  wire [1:0] mem_we;
  wire [17:0] waddr_all;
  wire [71:0] wword_all;
  wire [71:0] wmask_all;
  wire [71:0] q_all;
  wire [71:0] out_all;

  // upper write-data lines double as multiplier operand lines
  assign mult_operand_a_upper = d32_all[31:16];
  assign mult_operand_b_upper = d32_all[63:48];

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : port
      localparam [5:0] DW = (g == 0) ? DATA_W_A : DATA_W_B;
      localparam SLB = `BRAM_SLOT_BITS - $clog2(DW);
      localparam [5:0] SLM = (6'h01 << SLB) - 6'h01;
      localparam [1:0] MODE = (g == 0) ? WRITE_MODE_A : WRITE_MODE_B;
      localparam [35:0] DEF = (g == 0) ? OUT_DEFAULT_A : OUT_DEFAULT_B;

      wire [13:0] a14 = addr_all[14*g +: 14];
      wire [13:0] w14 = a14 >> SLB;
      wire [4:0] slot = a14[4:0] & SLM[4:0];
      wire en = en_all[g];
      wire [35:0] wword = place(d32_all[32*g +: 32], p4_all[4*g +: 4], slot, DW);
      wire [35:0] wmask = place(32'hFFFFFFFF, 4'hF, slot, DW);

      reg [1:0] sel_reg;
      reg [4:0] slot_reg;
      reg wf_reg;
      reg [35:0] wword_reg;
      reg [35:0] wmask_reg;
      reg [35:0] hold_reg;

      // storage access only while enabled; write needs both enables
      assign mem_en[g] = en;
      assign mem_we[g] = en & we_all[g];
      assign waddr_all[9*g +: 9] = w14[8:0];
      assign wword_all[36*g +: 36] = wword;
      assign wmask_all[36*g +: 36] = wmask;

      // write-first view merges the new slice over the old word
      wire [35:0] q = q_all[36*g +: 36];
      wire [35:0] merged = wf_reg ? ((q & ~wmask_reg) | (wword_reg & wmask_reg)) : q;
      wire [35:0] shown = (sel_reg == `OSEL_MEM) ? extract(merged, slot_reg, DW) :
                          (sel_reg == `OSEL_HOLD) ? hold_reg :
                          extract(DEF, 5'h00, DW);
      assign out_all[36*g +: 36] = shown;

      // output control; set/reset wins over read and write on the output
      always @(posedge clk) begin
        if (!reset_n) begin
          sel_reg <= `OSEL_DEFAULT;
          slot_reg <= 5'h00;
          wf_reg <= 1'b0;
          wword_reg <= 36'h000000000;
          wmask_reg <= 36'h000000000;
          hold_reg <= 36'h000000000;
        end else begin
          hold_reg <= shown;
          if (en) begin
            slot_reg <= slot;
            wword_reg <= wword;
            wmask_reg <= wmask;
            wf_reg <= 1'b0;
            if (ssr_all[g]) begin
              sel_reg <= `OSEL_DEFAULT;
            end else if (we_all[g]) begin
              case (MODE)
                `WM_WRITE_FIRST: begin
                  sel_reg <= `OSEL_MEM;
                  wf_reg <= 1'b1;
                end
                `WM_READ_FIRST: begin
                  sel_reg <= `OSEL_MEM;
                end
                `WM_NO_CHANGE: begin
                  sel_reg <= `OSEL_HOLD;
                end
                default: begin
                  sel_reg <= `OSEL_HOLD;
                end
              endcase
            end else begin
              sel_reg <= `OSEL_MEM;
            end
          end else begin
            sel_reg <= `OSEL_HOLD; // disabled port keeps its output
          end
        end
      end
    end
  endgenerate

  // one shared array seen by both ports
  block_store #(
    .INIT_WORD(INIT_WORD)
  ) store (
    .clk(clk),
    .en_a(mem_en[0]),
    .we_a(mem_we[0]),
    .addr_a(waddr_all[8:0]),
    .wdata_a(wword_all[35:0]),
    .wmask_a(wmask_all[35:0]),
    .rdata_a(q_all[35:0]),
    .en_b(mem_en[1]),
    .we_b(mem_we[1]),
    .addr_b(waddr_all[17:9]),
    .wdata_b(wword_all[71:36]),
    .wmask_b(wmask_all[71:36]),
    .rdata_b(q_all[71:36])
  ); // 512 x 36 = 18432 bits, 16384 of them data

  // narrowed outputs; parity reads zero on ports without parity
  assign read_data_a = out_all[DATA_W_A-1:0];
  assign read_parity_bits_a = out_all[32 +: PAR_W_A];
  assign read_data_b = out_all[36 +: DATA_W_B];
  assign read_parity_bits_b = out_all[68 +: PAR_W_B];

endmodule

//--- verification/port_driver.sv
/* user logic on one port of the block memory.
   assumes one shared clock; requests launch 1 ns after a rising edge. */
`timescale 1ns/1ps
module port_driver #(parameter DW = 8, parameter AW = 11, parameter PW = 1) (
  // clock
  input wire clk,
  // port controls and data
  output logic en,
  output logic we,
  output logic output_set_reset,
  output logic [AW-1:0] addr,
  output logic [DW-1:0] wdata,
  output logic [PW-1:0] wpar
);
  // idle port at time zero
  initial begin
    {en, we, output_set_reset, addr, wdata, wpar} = '0;
  end
  // one request per cycle, held until the next edge samples it
  task automatic op(input bit e, input bit w, input bit s, input logic [AW-1:0] a,
                    input logic [DW-1:0] d, input logic [PW-1:0] p);
    @(posedge clk);
    #1;
    en = e;
    we = w;
    output_set_reset = s;
    addr = a;
    wdata = d;
    wpar = p;
  endtask
  // released lines flip so a stale value can never look right
  task automatic idle();
    op(1'b0, 1'b0, 1'b0, ~addr, ~wdata, ~wpar);
  endtask
endmodule

//--- verification/dual_port_block_ram_asserts.sv
/* port-level checks of the block memory.
   assumes port a write-first and port b checked only for hold while disabled, reset, set/reset and its multiplier line. */
`timescale 1ns/1ps
module dual_port_block_ram_asserts #(
  parameter DATA_W_A = 8,
  parameter DATA_W_B = 32,
  parameter [35:0] OUT_DEFAULT_A = 36'h000000000,
  parameter [35:0] OUT_DEFAULT_B = 36'h000000000,
  parameter ADDR_W_A = 11,
  parameter PAR_W_A = 1,
  parameter PAR_W_B = 4
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // port a
  input wire enable_a,
  input wire write_enable_a,
  input wire output_set_reset_a,
  input wire [ADDR_W_A-1:0] addr_a,
  input wire [DATA_W_A-1:0] write_data_bus_a,
  input wire [PAR_W_A-1:0] write_parity_bits_a,
  input wire [DATA_W_A-1:0] read_data_a,
  input wire [PAR_W_A-1:0] read_parity_bits_a,
  // port b
  input wire enable_b,
  input wire output_set_reset_b,
  input wire [DATA_W_B-1:0] write_data_bus_b,
  input wire [DATA_W_B-1:0] read_data_b,
  input wire [PAR_W_B-1:0] read_parity_bits_b,
  // shared multiplier lines
  input wire [15:0] mult_operand_a_upper,
  input wire [15:0] mult_operand_b_upper
);
  // zero-extended so narrow ports expect zero on the shared lines
  wire [31:0] wa32 = 32'(write_data_bus_a);
  wire [31:0] wb32 = 32'(write_data_bus_b);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_hold_a: assert property (!enable_a |=> $stable(read_data_a))
    else $error("port a output moved while disabled");
  chk_hold_b: assert property (!enable_b |=> $stable({read_parity_bits_b, read_data_b}))
    else $error("port b output moved while disabled");
  chk_write_first_a: assert property (
    enable_a && write_enable_a && !output_set_reset_a |=>
    {read_parity_bits_a, read_data_a} == $past({write_parity_bits_a, write_data_bus_a}))
    else $error("port a write did not show new data");
  chk_write_read_a: assert property (
    enable_a && write_enable_a && !output_set_reset_a ##1
    enable_a && !write_enable_a && !output_set_reset_a && $stable(addr_a) |=>
    read_data_a == $past(write_data_bus_a, 2))
    else $error("port a read back differs from write");
  chk_set_reset_a: assert property (enable_a && output_set_reset_a |=>
    {read_parity_bits_a, read_data_a} == {OUT_DEFAULT_A[32 +: PAR_W_A], OUT_DEFAULT_A[DATA_W_A-1:0]})
    else $error("port a set/reset value wrong");
  chk_set_reset_b: assert property (enable_b && output_set_reset_b |=>
    read_data_b == OUT_DEFAULT_B[DATA_W_B-1:0])
    else $error("port b set/reset value wrong");
  chk_reset_b: assert property (disable iff (1'b0) !reset_n |=>
    read_data_b == OUT_DEFAULT_B[DATA_W_B-1:0])
    else $error("port b output not default in reset");
  chk_mult_lines: assert property (mult_operand_a_upper == wa32[31:16] &&
    mult_operand_b_upper == wb32[31:16])
    else $error("multiplier lines differ from write data");
endmodule
bind dual_port_block_ram dual_port_block_ram_asserts #(.DATA_W_A(DATA_W_A),
  .DATA_W_B(DATA_W_B), .OUT_DEFAULT_A(OUT_DEFAULT_A), .OUT_DEFAULT_B(OUT_DEFAULT_B),
  .ADDR_W_A(ADDR_W_A), .PAR_W_A(PAR_W_A), .PAR_W_B(PAR_W_B)) u_chk (.clk(clk),
  .reset_n(reset_n), .enable_a(enable_a), .write_enable_a(write_enable_a),
  .output_set_reset_a(output_set_reset_a), .addr_a(addr_a),
  .write_data_bus_a(write_data_bus_a), .write_parity_bits_a(write_parity_bits_a),
  .read_data_a(read_data_a), .read_parity_bits_a(read_parity_bits_a), .enable_b(enable_b),
  .output_set_reset_b(output_set_reset_b), .write_data_bus_b(write_data_bus_b),
  .read_data_b(read_data_b), .read_parity_bits_b(read_parity_bits_b),
  .mult_operand_a_upper(mult_operand_a_upper), .mult_operand_b_upper(mult_operand_b_upper));

//--- verification/tb.sv
/* self-checking bench: port a 8+1 bits write-first, port b 32+4 bits read-first.
   assumes the port drivers and the bound checker are compiled beside it. */
`timescale 1ns/1ps
`include "dual_port_block_ram_map.vh"
`define CHECK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb;
  localparam [35:0] DEF_A = 36'h1000000A5;
  localparam [35:0] DEF_B = 36'h312345678;
  localparam [35:0] INIT = 36'h611223344;
  // port geometry: 9-bit port a, 36-bit port b
  localparam int DW_A = 8;
  localparam int DW_B = 32;
  localparam int AW_A = 11;
  localparam int AW_B = 9;
  localparam int PW_A = 1;
  localparam int PW_B = 4;
  logic clk;
  logic reset_n;
  int err_count;
  int n_checks;
  wire en_a, we_a, ssr_a, en_b, we_b, ssr_b;
  wire [10:0] ad_a;
  wire [8:0] ad_b;
  wire [7:0] wd_a, rd_a;
  wire [31:0] wd_b, rd_b;
  wire [0:0] wp_a, rp_a;
  wire [3:0] wp_b, rp_b;
  wire [15:0] mult_a, mult_b;
  // memory under test, mismatched widths for bus matching
  dual_port_block_ram #(.DATA_W_A(DW_A), .DATA_W_B(DW_B), .WRITE_MODE_B(`WM_READ_FIRST),
    .OUT_DEFAULT_A(DEF_A), .OUT_DEFAULT_B(DEF_B), .INIT_WORD(INIT)) u_dut (.clk(clk),
    .reset_n(reset_n), .enable_a(en_a), .write_enable_a(we_a), .output_set_reset_a(ssr_a),
    .addr_a(ad_a), .write_data_bus_a(wd_a), .write_parity_bits_a(wp_a), .read_data_a(rd_a),
    .read_parity_bits_a(rp_a), .enable_b(en_b), .write_enable_b(we_b),
    .output_set_reset_b(ssr_b), .addr_b(ad_b), .write_data_bus_b(wd_b),
    .write_parity_bits_b(wp_b), .read_data_b(rd_b), .read_parity_bits_b(rp_b),
    .mult_operand_a_upper(mult_a), .mult_operand_b_upper(mult_b));
  // user logic on both ports
  port_driver #(.DW(DW_A), .AW(AW_A), .PW(PW_A)) u_pa (.clk(clk), .en(en_a), .we(we_a),
    .output_set_reset(ssr_a), .addr(ad_a), .wdata(wd_a), .wpar(wp_a));
  port_driver #(.DW(DW_B), .AW(AW_B), .PW(PW_B)) u_pb (.clk(clk), .en(en_b), .we(we_b),
    .output_set_reset(ssr_b), .addr(ad_b), .wdata(wd_b), .wpar(wp_b));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // four bytes through a, one wide word back through b
  task automatic t_narrow_to_wide();
    for (int k = 0; k < 4; k++) begin
      u_pa.op(1'b1, 1'b1, 1'b0, 11'(4 + k), 8'(8'hA0 + k), 1'(k));
      u_pa.idle();
      `CHECK({rp_a, rd_a}, {1'(k), 8'(8'hA0 + k)})
    end
    u_pb.op(1'b1, 1'b0, 1'b0, 9'h001, '0, '0);
    u_pb.idle();
    `CHECK({rp_b, rd_b}, 36'hAA3A2A1A0)
  endtask
  // wide word through b, split into bytes at a
  task automatic t_wide_to_narrow();
    u_pb.op(1'b1, 1'b1, 1'b0, 9'h002, 32'h89ABCDEF, 4'h5);
    u_pb.idle();
    `CHECK({rp_b, rd_b}, INIT)
    u_pb.op(1'b1, 1'b0, 1'b0, 9'h002, '0, '0);
    u_pb.idle();
    `CHECK({rp_b, rd_b}, 36'h589ABCDEF)
    for (int k = 0; k < 4; k++) begin
      u_pa.op(1'b1, 1'b0, 1'b0, 11'(8 + k), '0, '0);
      u_pa.idle();
      `CHECK({rp_a, rd_a}, {1'(4'h5 >> k), 8'(32'h89ABCDEF >> (8 * k))})
    end
  endtask
  // refused write, back-to-back read, set/reset with a write underneath
  task automatic t_refuse_and_default();
    u_pa.op(1'b0, 1'b1, 1'b0, 11'd12, 8'h55, 1'b1);
    u_pa.op(1'b1, 1'b0, 1'b0, 11'd12, '0, '0);
    u_pa.idle();
    `CHECK({rp_a, rd_a}, {INIT[32], INIT[7:0]})
    u_pa.op(1'b1, 1'b1, 1'b0, 11'd14, 8'h5A, 1'b0);
    u_pa.op(1'b1, 1'b0, 1'b0, 11'd14, '0, '0);
    u_pa.idle();
    `CHECK(rd_a, 8'h5A)
    fork
      u_pa.op(1'b1, 1'b1, 1'b1, 11'd13, 8'h3C, 1'b0);
      u_pb.op(1'b1, 1'b0, 1'b1, 9'h000, '0, '0);
    join
    fork
      u_pa.idle();
      u_pb.idle();
    join
    `CHECK({rp_a, rd_a}, {DEF_A[32], DEF_A[7:0]})
    `CHECK({rp_b, rd_b}, DEF_B)
    u_pb.op(1'b1, 1'b0, 1'b0, 9'h003, '0, '0);
    u_pb.idle();
    `CHECK({rp_b, rd_b}, 36'h0115A3C44)
  endtask
  // shared operand lines follow write data even on an idle port; narrow port a gives zero
  task automatic t_mult_lines();
    fork
      u_pa.op(1'b0, 1'b0, 1'b0, '0, 8'hFF, '0);
      u_pb.op(1'b0, 1'b0, 1'b0, '0, 32'hBEEF1234, '0);
    join
    #1;
    `CHECK(mult_a, 16'h0000)
    `CHECK(mult_b, 16'hBEEF)
    fork
      u_pa.idle();
      u_pb.idle();
    join
  endtask
  // main sequence: reset, defaults, initial contents, then traffic
  initial begin
    reset_n = 1'b0;
    err_count = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    #1;
    reset_n = 1'b1;
    `CHECK({rp_a, rd_a}, {DEF_A[32], DEF_A[7:0]})
    `CHECK({rp_b, rd_b}, DEF_B)
    u_pb.op(1'b1, 1'b0, 1'b0, 9'h005, '0, '0);
    u_pb.idle();
    `CHECK({rp_b, rd_b}, INIT)
    t_narrow_to_wide();
    t_wide_to_narrow();
    t_refuse_and_default();
    t_mult_lines();
    end_of_test();
  end
  // watchdog, far beyond the roughly 50 cycles the run needs
  initial begin
    #20000;
    err_count++;
    end_of_test();
  end
endmodule
